// ### rtl/eipc_top.sv
`timescale 1ns/1ps
module eipc_top
	import eipc_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_ext_int_pin,
	output logic o_ext_int_request,
	output logic o_pull_up_enable,
	output logic o_pull_down_enable,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic pin_sync;
	logic pin_prev_q;
	logic ext_int_level_mode_q;
	logic ext_int_request_enable_q;
	logic ext_int_pin_enable_q;
	logic ext_int_polarity_select_q;
	logic ext_int_pull_disable_q;
	logic ext_int_event_flag_q;
	logic [31:0] awaddr_q;
	logic aw_held_q;
	logic [7:0] wdata_q;
	logic wstrb0_q;
	logic w_held_q;
	logic wr_fire;
	logic wr_hit;
	logic ack_write;
	logic asserted_level;
	logic edge_seen;
	logic event_set;
	logic [7:0] status_read;

	eipc_sync u_pin_sync (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_async(i_ext_int_pin),
		.o_sync(pin_sync)
	);

	// Previous sample starts low, so a pin held high at release looks like a
	// rising edge; this only matters once the pin function is enabled.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pin_prev_q <= 1'b0;
		end else begin
			pin_prev_q <= pin_sync;
		end
	end

	assign asserted_level = ext_int_polarity_select_q ? pin_sync : !pin_sync;
	assign edge_seen = ext_int_polarity_select_q ?
		(pin_sync && !pin_prev_q) : (!pin_sync && pin_prev_q);
	assign event_set = ext_int_pin_enable_q &&
		(edge_seen || (ext_int_level_mode_q && asserted_level));

	// Write channel: address and data are latched independently, in any order.
	assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
	assign wr_hit = awaddr_q[31:2] == 30'(EIPC_ADDR_STATUS_CONTROL >> 2);
	assign ack_write = wr_fire && wr_hit && wstrb0_q &&
		wdata_q[EIPC_BIT_EVENT_ACK];

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			aw_held_q <= 1'b0;
			awaddr_q <= 32'h00000000;
			s_axi_awready <= 1'b1;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (wr_fire) begin
			aw_held_q <= 1'b0;
		end else if (!aw_held_q && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			w_held_q <= 1'b0;
			wdata_q <= 8'h00;
			wstrb0_q <= 1'b0;
			s_axi_wready <= 1'b1;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_q <= 1'b1;
			wdata_q <= s_axi_wdata[7:0];
			wstrb0_q <= s_axi_wstrb[0];
			s_axi_wready <= 1'b0;
		end else if (wr_fire) begin
			w_held_q <= 1'b0;
		end else if (!w_held_q && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= EIPC_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? EIPC_RESP_OKAY : EIPC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ext_int_level_mode_q <= EIPC_CONTROL_RESET[EIPC_BIT_LEVEL_MODE];
			ext_int_request_enable_q <= EIPC_CONTROL_RESET[EIPC_BIT_REQUEST_ENABLE];
			ext_int_pin_enable_q <= EIPC_CONTROL_RESET[EIPC_BIT_PIN_ENABLE];
			ext_int_polarity_select_q <= EIPC_CONTROL_RESET[EIPC_BIT_POLARITY];
			ext_int_pull_disable_q <= EIPC_CONTROL_RESET[EIPC_BIT_PULL_DISABLE];
		end else if (wr_fire && wr_hit && wstrb0_q) begin
			ext_int_level_mode_q <= wdata_q[EIPC_BIT_LEVEL_MODE];
			ext_int_request_enable_q <= wdata_q[EIPC_BIT_REQUEST_ENABLE];
			ext_int_pin_enable_q <= wdata_q[EIPC_BIT_PIN_ENABLE];
			ext_int_polarity_select_q <= wdata_q[EIPC_BIT_POLARITY];
			ext_int_pull_disable_q <= wdata_q[EIPC_BIT_PULL_DISABLE];
		end
	end

	// A new event beats a simultaneous acknowledge, and in level mode the
	// still-asserted level re-sets the flag, so it cannot be cleared.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ext_int_event_flag_q <= EIPC_CONTROL_RESET[EIPC_BIT_EVENT_FLAG];
		end else if (event_set) begin
			ext_int_event_flag_q <= 1'b1;
		end else if (ack_write) begin
			ext_int_event_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_ext_int_request <= 1'b0;
			o_pull_up_enable <= 1'b0;
			o_pull_down_enable <= 1'b0;
		end else begin
			o_ext_int_request <= ext_int_request_enable_q &&
				ext_int_event_flag_q;
			o_pull_up_enable <= ext_int_pin_enable_q && !ext_int_pull_disable_q &&
				!ext_int_polarity_select_q;
			o_pull_down_enable <= ext_int_pin_enable_q && !ext_int_pull_disable_q &&
				ext_int_polarity_select_q;
		end
	end

	always_comb begin
		status_read = 8'h00;
		status_read[EIPC_BIT_LEVEL_MODE] = ext_int_level_mode_q;
		status_read[EIPC_BIT_REQUEST_ENABLE] = ext_int_request_enable_q;
		status_read[EIPC_BIT_EVENT_FLAG] = ext_int_event_flag_q;
		status_read[EIPC_BIT_PIN_ENABLE] = ext_int_pin_enable_q;
		status_read[EIPC_BIT_POLARITY] = ext_int_polarity_select_q;
		status_read[EIPC_BIT_PULL_DISABLE] = ext_int_pull_disable_q;
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= EIPC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			if (s_axi_araddr[31:2] == 30'(EIPC_ADDR_STATUS_CONTROL >> 2)) begin
				s_axi_rdata <= {24'h000000, status_read};
				s_axi_rresp <= EIPC_RESP_OKAY;
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= EIPC_RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule : eipc_top

// ### include/eipc_pkg.sv
package eipc_pkg;
	// Register byte address on the AXI4-Lite bus.
	localparam logic [3:0] EIPC_ADDR_STATUS_CONTROL = 4'h0;
	localparam int EIPC_BIT_LEVEL_MODE = 0;
	localparam int EIPC_BIT_REQUEST_ENABLE = 1;
	localparam int EIPC_BIT_EVENT_ACK = 2;
	localparam int EIPC_BIT_EVENT_FLAG = 3;
	localparam int EIPC_BIT_PIN_ENABLE = 4;
	localparam int EIPC_BIT_POLARITY = 5;
	localparam int EIPC_BIT_PULL_DISABLE = 6;
	localparam logic [7:0] EIPC_CONTROL_RESET = 8'h00;
	localparam logic [1:0] EIPC_RESP_OKAY = 2'h0;
	localparam logic [1:0] EIPC_RESP_SLVERR = 2'h2;
endpackage : eipc_pkg

// ### rtl/eipc_sync.sv
`timescale 1ns/1ps
module eipc_sync (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_async,
	output logic o_sync
);
	logic meta_q;

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta_q <= 1'b0;
			o_sync <= 1'b0;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule : eipc_sync

// ### verif/eipc_pin_src.sv
`timescale 1ns/1ps
module eipc_pin_src (
	input wire logic i_clock,
	input wire logic i_drive,
	input wire logic i_level,
	input wire logic i_pull_up,
	input wire logic i_pull_down,
	output logic o_pin
);
	logic last_q;
	always_ff @(posedge i_clock) last_q <= o_pin;
	// A released pin without a pull wanders, so it never looks idle.
	assign o_pin = i_drive ? i_level : i_pull_up ? 1'b1 : i_pull_down ? 1'b0 : ~last_q;
endmodule : eipc_pin_src

// ### verif/eipc_monitor.sv
`timescale 1ns/1ps
module eipc_monitor
	import eipc_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic o_ext_int_request,
	input wire logic o_pull_up_enable,
	input wire logic o_pull_down_enable,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid
);
	logic rd_ok;
	// Unmapped reads return zero data, which says nothing about the setup.
	assign rd_ok = s_axi_rvalid && s_axi_rresp == EIPC_RESP_OKAY;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	AST_RD_ZERO: assert property (s_axi_rvalid
		|-> !s_axi_rdata[7] && !s_axi_rdata[2])
		else $error("Bit 7 or bit 2 read as one.");
	AST_PULL_EXCL: assert property (!(o_pull_up_enable && o_pull_down_enable))
		else $error("Both pulls on.");
	AST_PULL_OFF: assert property (rd_ok && (s_axi_rdata[6] || !s_axi_rdata[4])
		|-> !o_pull_up_enable && !o_pull_down_enable)
		else $error("Pull on while off.");
	AST_PULL_UP: assert property (rd_ok && o_pull_up_enable
		|-> s_axi_rdata[6:4] == 3'h1) else $error("Pull-up with wrong setup.");
	AST_PULL_DN: assert property (rd_ok && o_pull_down_enable
		|-> s_axi_rdata[6:4] == 3'h3) else $error("Pull-down with wrong setup.");
	AST_REQ_ON: assert property (rd_ok && s_axi_rdata[1] && s_axi_rdata[3]
		|-> o_ext_int_request) else $error("Request missing.");
	AST_REQ_OFF: assert property (rd_ok && !s_axi_rdata[1]
		|-> !o_ext_int_request) else $error("Request while gated.");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("Read taken while busy.");
	cover property (s_axi_rvalid && s_axi_rdata[3]);
	cover property (o_ext_int_request);
	cover property (o_pull_up_enable);
endmodule : eipc_monitor
bind eipc_top eipc_monitor eipc_monitor_inst (.*);

// ### verif/eipc_top_test.sv
`timescale 1ns/1ps
module eipc_top_test;
	import eipc_pkg::*;
	logic i_clock, i_reset_n, i_ext_int_pin, o_ext_int_request, drv, lvl;
	logic o_pull_up_enable, o_pull_down_enable;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] w;
	logic [19:0] steps [18];
	int miscompares = 0, checks = 0, cyc = 0;
	eipc_top eipc_top_inst (.*);
	eipc_pin_src eipc_pin_src_inst (.i_clock(i_clock), .i_drive(drv), .i_level(lvl),
		.i_pull_up(o_pull_up_enable), .i_pull_down(o_pull_down_enable),
		.o_pin(i_ext_int_pin));
	task automatic chk(input string n, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [31:0] a, d, input logic [3:0] s);
		@(posedge i_clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge i_clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [31:0] a);
		@(posedge i_clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge i_clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rdv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic give_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	initial begin
		i_clock = 1'b0;
		forever #20 i_clock = ~i_clock;
	end
	// The table runs in a few hundred cycles, so this only trips on a hang.
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			miscompares++;
			give_verdict();
		end
	end
	initial begin
		{i_reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, lvl, drv} = 4'h1;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = 100'h0;
		// Entry: write, expected read, then release, level and request bits.
		steps = '{20'h73730, 20'h32320, 20'h323A3, 20'h36322, 20'h333B3,
			20'h373B3, 20'h333B1, 20'h37330, 20'h10102, 20'h10180,
			20'h14100, 20'h00002, 20'h00000, 20'h11190, 20'h15192,
			20'h15112, 20'h10106, 20'h50584};
		repeat (6) @(posedge i_clock);
		i_reset_n <= 1'b1;
		rd(32'h0);
		chk("reset value", rdv, 32'h0);
		wr(32'h0, 32'hFF, 4'h0);
		rd(32'h0);
		chk("unstrobed write", rdv, 32'h0);
		rd(32'h4);
		chk("unmapped resp", {30'h0, rr}, {30'h0, EIPC_RESP_SLVERR});
		$display("register access done");
		foreach (steps[i]) begin
			w = steps[i][19:12];
			wr(32'h0, {24'h0, w}, 4'h1);
			lvl <= steps[i][1];
			drv <= !steps[i][2];
			repeat (6) @(posedge i_clock);
			rd(32'h0);
			chk("status", rdv, {24'h0, steps[i][11:4]});
			chk("request", {31'h0, o_ext_int_request}, {31'h0, steps[i][0]});
			chk("pull up", {31'h0, o_pull_up_enable}, {31'h0, w[4] & ~w[6] & ~w[5]});
			chk("pull dn", {31'h0, o_pull_down_enable}, {31'h0, w[4] & ~w[6] & w[5]});
			$display("step %0d done", i);
		end
		wr(32'h0, 32'h33, 4'h1);
		repeat (6) @(posedge i_clock);
		chk("pull dn set", {31'h0, o_pull_down_enable}, 32'h1);
		i_reset_n <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_reset_n <= 1'b1;
		rd(32'h0);
		chk("reset again", rdv, 32'h0);
		chk("pull dn reset", {31'h0, o_pull_down_enable}, 32'h0);
		$display("mid-run reset done");
		give_verdict();
	end
endmodule : eipc_top_test
